/* File: vipc_pkg.sv */
// shared constants, types and register map of the vectored interrupt priority control
package vipc_pkg;

    // ==================================================================
    // register map (byte addresses on the plain register port)
    // ==================================================================
    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned DATA_W          = 32;
    localparam logic [11:0] CTRL_BASE_ADDR  = 12'h000;   // control reg of number n at +4*n
    localparam logic [11:0] CTRL_LAST_ADDR  = 12'h07c;
    localparam logic [11:0] FLAG_ADDR       = 12'h100;   // cpu flag word
    localparam logic [11:0] VBASE_ADDR      = 12'h104;   // vector base pointer
    localparam logic [11:0] CFG_ADDR        = 12'h108;   // address match enable, i2c mode
    localparam logic [11:0] PEND_ADDR       = 12'h10c;   // read only: pending winner
    localparam logic [11:0] CAUSE_ADDR      = 12'h35f;   // request cause selection

    // ==================================================================
    // field positions
    // ==================================================================
    localparam int unsigned CTRL_LVL_LSB    = 0;         // priority level b2..b0
    localparam int unsigned CTRL_REQ_BIT    = 3;         // request bit
    localparam int unsigned FLAG_IEN_BIT    = 6;         // global enable
    localparam int unsigned FLAG_IPL_LSB    = 12;        // threshold, three bits
    localparam int unsigned CFG_AMATCH_BIT  = 0;
    localparam int unsigned CFG_I2C_BIT     = 1;
    localparam int unsigned CAUSE_SEL8_BIT  = 6;         // number 8: 0 serial 4, 1 external 5
    localparam int unsigned CAUSE_SEL9_BIT  = 7;         // number 9: 0 serial 3, 1 external 4
    localparam int unsigned PEND_VALID_BIT  = 8;

    // ==================================================================
    // numbering and reset values
    // ==================================================================
    localparam int unsigned NUM_W           = 6;         // software numbers 0..63
    localparam int unsigned LVL_W           = 3;
    localparam int unsigned VADDR_W         = 20;
    localparam int unsigned FIRST_MASKABLE  = 4;
    localparam int unsigned LAST_MASKABLE   = 31;
    localparam logic [2:0]  LVL_RST         = 3'h0;
    localparam logic [2:0]  IPL_RST         = 3'h0;
    localparam logic [19:0] VBASE_RST       = 20'h00000;
    localparam logic [7:0]  BRK_REDIRECT    = 8'hff;

    // ==================================================================
    // fixed vector area at the top of memory, four bytes per entry
    // ==================================================================
    localparam logic [19:0] VEC_UNDEF       = 20'hfffdc;
    localparam logic [19:0] VEC_OVF         = 20'hfffe0;
    localparam logic [19:0] VEC_BRK         = 20'hfffe4;
    localparam logic [19:0] VEC_AMATCH      = 20'hfffe8;
    localparam logic [19:0] VEC_SSTEP       = 20'hfffec;
    localparam logic [19:0] VEC_WDOG        = 20'hffff0;
    localparam logic [19:0] VEC_DBG         = 20'hffff4;
    localparam logic [19:0] VEC_NMI         = 20'hffff8;
    localparam logic [19:0] VEC_RESET       = 20'hffffc;

    typedef enum logic [3:0] {
        VK_UNDEF, VK_OVF, VK_BRK, VK_AMATCH, VK_SSTEP,
        VK_WDOG, VK_DBG, VK_NMI, VK_RESET, VK_SOFT
    } vipc_vkind_e;

    // vector lookup request from the cpu core
    typedef struct packed {
        logic        req;
        vipc_vkind_e kind;
        logic [5:0]  num;        // software number for VK_SOFT
        logic [7:0]  brk_byte;   // byte read from the fixed break entry
    } vipc_vreq_s;

    // one-cycle request pulses from the peripherals
    typedef struct packed {
        logic [5:0] ext_req;     // external request lines 0..5
        logic [4:0] timer_a;
        logic [5:0] timer_b;
        logic       sync_serial_3;
        logic       sync_serial_4;
        logic       bus_coll;
        logic       dma0;
        logic       dma1;
        logic       key_in;
        logic       adc;
        logic       u2_tx;
        logic       u2_rx;
        logic       u2_nack;
        logic       u2_ack;
        logic       u0_tx;
        logic       u0_rx;
        logic       u1_tx;
        logic       u1_rx;
    } vipc_evt_s;

endpackage

/* File: vipc_prio_resolve.sv */
// combinational winner search over the maskable request bits
`timescale 1ns/10ps

module vipc_prio_resolve #(
    parameter int unsigned N_SRC = 32
) (
    input  wire logic [N_SRC-1:0] req,
    input  wire logic [N_SRC-1:0][2:0] lvl,
    input  wire logic             ien,
    input  wire logic [2:0]       cpu_priority_threshold,
    output logic                  any,
    output logic [4:0]            num,
    output logic [2:0]            win_lvl
);

    // ==================================================================
    // scan downward so that on a level tie the lowest number wins
    // ==================================================================
    always_comb begin
        any     = 1'b0;
        num     = 5'h00;
        win_lvl = 3'h0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            // all three conditions together: enable, request, level over threshold
            if (ien && req[i] && (lvl[i] > cpu_priority_threshold) && (!any || lvl[i] >= win_lvl)) begin // see RQ20
                any     = 1'b1;
                num     = 5'(i);
                win_lvl = lvl[i]; // see RQ24
            end
        end
    end

endmodule // vipc_prio_resolve

/* File: vipc_top.sv */
// vectored interrupt priority control: request bits, levels, gating and vector addresses
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps

// Overview of operation
// RQ1: fixed vectors sit at top of memory from fffdc, four bytes each.
// RQ2: undefined opcode at fffdc, overflow at fffe0, break at fffe4.
// RQ3: break entry reading ff redirects to the relocatable break entry.
// RQ4: address match fffe8 gated by its enable, single step fffec, watchdog ffff0.
// RQ5: debugger break ffff4, non-maskable pin ffff8, reset ffffc.
// RQ6: relocatable area is 256 bytes starting at the writable base pointer.
// RQ7: software number n reads base plus four times n.
// RQ8: numbers 0 and 32 to 63 ignore the global enable.
// RQ9: numbers 4 to 9: external 3, timers b5 b4 b3, shared serial/external pairs.
// RQ10: numbers 10 to 20: collision, dma, key, adc, uart2, uart0, uart1.
// RQ11: timers a0-a4 at 21-25, b0-b2 at 26-28, external 0-2 at 29-31.
// RQ12: cause bits 6 and 7 at 35f choose shared vector sources.
// RQ13: in i2c mode uart2 vectors carry nack and ack events.
// RQ14: gating by enable, request and level applies to maskable sources only.
// RQ15: each source has request bit and level; enable and threshold in flag word.
// RQ16: global enable one permits, zero blocks maskable; resets to zero.
// RQ17: hardware sets request on event and clears it on acceptance.
// RQ18: software clears a request by writing zero; writing one does nothing.
// RQ19: request allowed only when level strictly above threshold; level zero disables.
// RQ20: accept only when enable, request and level-above-threshold all hold.
// RQ21: enable, requests, levels and threshold never disturb one another.
// RQ22: three-bit level is binary, zero off, one lowest, seven highest.
// RQ23: threshold of all ones blocks every maskable interrupt.
// RQ24: equal highest levels resolve to the lowest number.
module vipc_top (
    input  wire logic                SYS_CLK,
    input  wire logic                SYS_RST,
    input  wire logic [11:0]         ADDR,
    input  wire logic [31:0]         WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output logic [31:0]              RDATA,
    input  wire vipc_pkg::vipc_evt_s EVT,
    input  wire logic                ACK,
    input  wire logic [4:0]          ACK_NUM,
    output logic                     IRQ_PEND,
    output logic [5:0]               IRQ_NUM,
    output logic [2:0]               IRQ_LEVEL,
    input  wire vipc_pkg::vipc_vreq_s VREQ,
    output logic                     VEC_VALID,
    output logic [19:0]              VEC_ADDR,
    output logic                     VEC_REFUSED
);

    // ==================================================================
    // state
    // ==================================================================
    logic [31:0]       req_q;
    logic [31:0][2:0]  lvl_q;
    logic              ien_q;
    logic [2:0]        ipl_q;
    logic [19:0]       vbase_q;
    logic              amatch_en_q;
    logic              i2c_mode_q;
    logic [1:0]        cause_q;
    logic [31:0]       rdata_q;
    logic              pend_q;
    logic [4:0]        pend_num_q;
    logic [2:0]        pend_lvl_q;
    logic              vvalid_q;
    logic [19:0]       vaddr_q;
    logic              vref_q;
    logic [31:0]       evt_vec;
    logic              res_any;
    logic [4:0]        res_num;
    logic [2:0]        res_lvl;
    logic              ctrl_hit;
    logic [4:0]        ctrl_idx;

    // ==================================================================
    // event routing onto software numbers
    // ==================================================================
    function automatic logic [31:0] route_events(input vipc_pkg::vipc_evt_s e,
                                                 input logic [1:0] cause,
                                                 input logic i2c);
        logic [31:0] v;
        v     = 32'h0000_0000;
        v[4]  = e.ext_req[3];                                          // see RQ9
        v[5]  = e.timer_b[5];
        v[6]  = e.timer_b[4];
        v[7]  = e.timer_b[3];
        v[8]  = cause[0] ? e.ext_req[5] : e.sync_serial_4;              // see RQ12
        v[9]  = cause[1] ? e.ext_req[4] : e.sync_serial_3;              // see RQ12
        v[10] = e.bus_coll;                                            // see RQ10
        v[11] = e.dma0;
        v[12] = e.dma1;
        v[13] = e.key_in;
        v[14] = e.adc;
        v[15] = i2c ? e.u2_nack : e.u2_tx;                             // see RQ13
        v[16] = i2c ? e.u2_ack : e.u2_rx;                              // see RQ13
        v[17] = e.u0_tx;
        v[18] = e.u0_rx;
        v[19] = e.u1_tx;
        v[20] = e.u1_rx;
        v[25:21] = e.timer_a;                                          // see RQ11
        v[28:26] = e.timer_b[2:0];                                     // see RQ11
        v[31:29] = e.ext_req[2:0];                                     // see RQ11
        return v;
    endfunction

    assign evt_vec  = route_events(EVT, cause_q, i2c_mode_q);
    assign ctrl_hit = (ADDR >= vipc_pkg::CTRL_BASE_ADDR) && (ADDR <= vipc_pkg::CTRL_LAST_ADDR)
                      && (ADDR[1:0] == 2'h0);
    assign ctrl_idx = ADDR[6:2];

    // ==================================================================
    // request bits: set wins over any clear in the same cycle
    // ==================================================================
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            req_q <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < 32; i++) begin
                if (i < vipc_pkg::FIRST_MASKABLE) begin
                    req_q[i] <= 1'b0;             // numbers 0..3 have no peripheral
                end else if (evt_vec[i]) begin
                    req_q[i] <= 1'b1;             // see RQ17
                end else if (ACK && ACK_NUM == 5'(i)) begin
                    req_q[i] <= 1'b0;             // see RQ17
                end else if (WR && ctrl_hit && ctrl_idx == 5'(i)
                             && !WDATA[vipc_pkg::CTRL_REQ_BIT]) begin
                    req_q[i] <= 1'b0;             // a written one is ignored, see RQ18
                end
            end
        end
    end

    // ==================================================================
    // priority levels, touched only by their own control register
    // ==================================================================
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            lvl_q <= '0;
        end else if (WR && ctrl_hit && ctrl_idx >= 5'(vipc_pkg::FIRST_MASKABLE)) begin
            lvl_q[ctrl_idx] <= WDATA[vipc_pkg::CTRL_LVL_LSB +: 3];      // see RQ15, RQ21, RQ22
        end
    end

    // ==================================================================
    // flag word, base pointer and configuration
    // ==================================================================
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ien_q <= 1'b0;                                             // see RQ16
            ipl_q <= vipc_pkg::IPL_RST;
        end else if (WR && ADDR == vipc_pkg::FLAG_ADDR) begin
            ien_q <= WDATA[vipc_pkg::FLAG_IEN_BIT];                    // see RQ15
            ipl_q <= WDATA[vipc_pkg::FLAG_IPL_LSB +: 3];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            vbase_q <= vipc_pkg::VBASE_RST;
        end else if (WR && ADDR == vipc_pkg::VBASE_ADDR) begin
            vbase_q <= WDATA[19:0];                                    // see RQ6
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            amatch_en_q <= 1'b0;
            i2c_mode_q  <= 1'b0;
            cause_q     <= 2'h0;
        end else begin
            if (WR && ADDR == vipc_pkg::CFG_ADDR) begin
                amatch_en_q <= WDATA[vipc_pkg::CFG_AMATCH_BIT];
                i2c_mode_q  <= WDATA[vipc_pkg::CFG_I2C_BIT];
            end
            if (WR && ADDR == vipc_pkg::CAUSE_ADDR) begin
                cause_q <= {WDATA[vipc_pkg::CAUSE_SEL9_BIT], WDATA[vipc_pkg::CAUSE_SEL8_BIT]};
            end
        end
    end

    // ==================================================================
    // read port: data stand one cycle after the strobe, zero elsewhere
    // ==================================================================
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !RD) begin
            rdata_q <= 32'h0000_0000;
        end else if (ctrl_hit) begin
            rdata_q <= {28'h0, req_q[ctrl_idx], lvl_q[ctrl_idx]};
        end else begin
            case (ADDR)
                vipc_pkg::FLAG_ADDR:  rdata_q <= {17'h0, ipl_q, 5'h0, ien_q, 6'h0};
                vipc_pkg::VBASE_ADDR: rdata_q <= {12'h0, vbase_q};
                vipc_pkg::CFG_ADDR:   rdata_q <= {30'h0, i2c_mode_q, amatch_en_q};
                vipc_pkg::PEND_ADDR:  rdata_q <= {20'h0, pend_lvl_q, pend_q, 3'h0, pend_num_q};
                vipc_pkg::CAUSE_ADDR: rdata_q <= {24'h0, cause_q, 6'h0};
                default:              rdata_q <= 32'h0000_0000;        // unmapped reads zero
            endcase
        end
    end

    // ==================================================================
    // maskable arbitration; the winner is registered toward the core
    // ==================================================================
    vipc_prio_resolve #(
        .N_SRC (32)
    ) u_resolve (
        .req     (req_q),
        .lvl     (lvl_q),
        .ien     (ien_q),
        .cpu_priority_threshold     (ipl_q),
        .any     (res_any),
        .num     (res_num),
        .win_lvl (res_lvl)
    );

    // strictly-greater compare inside the resolver, see RQ19, RQ23
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pend_q     <= 1'b0;
            pend_num_q <= 5'h00;
            pend_lvl_q <= 3'h0;
        end else begin
            pend_q     <= res_any;                                     // see RQ14, RQ16
            pend_num_q <= res_num;
            pend_lvl_q <= res_lvl;
        end
    end

    // ==================================================================
    // vector address generation; never gated by the enable or levels
    // ==================================================================
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            vvalid_q <= 1'b0;
            vaddr_q  <= 20'h00000;
            vref_q   <= 1'b0;
        end else begin
            vvalid_q <= VREQ.req;
            vref_q   <= 1'b0;
            if (VREQ.req) begin
                case (VREQ.kind)                                       // see RQ1, RQ14
                    vipc_pkg::VK_UNDEF:  vaddr_q <= vipc_pkg::VEC_UNDEF;   // see RQ2
                    vipc_pkg::VK_OVF:    vaddr_q <= vipc_pkg::VEC_OVF;     // see RQ2
                    vipc_pkg::VK_BRK: begin
                        // an erased entry hands over to relocatable entry 0
                        vaddr_q <= (VREQ.brk_byte == vipc_pkg::BRK_REDIRECT) ?
                                   vbase_q : vipc_pkg::VEC_BRK;         // see RQ2, RQ3
                    end
                    vipc_pkg::VK_AMATCH: begin
                        vaddr_q <= vipc_pkg::VEC_AMATCH;               // see RQ4
                        vref_q  <= !amatch_en_q;                       // see RQ4
                    end
                    vipc_pkg::VK_SSTEP:  vaddr_q <= vipc_pkg::VEC_SSTEP;   // see RQ4
                    vipc_pkg::VK_WDOG:   vaddr_q <= vipc_pkg::VEC_WDOG;    // see RQ4
                    vipc_pkg::VK_DBG:    vaddr_q <= vipc_pkg::VEC_DBG;     // see RQ5
                    vipc_pkg::VK_NMI:    vaddr_q <= vipc_pkg::VEC_NMI;     // see RQ5
                    vipc_pkg::VK_RESET:  vaddr_q <= vipc_pkg::VEC_RESET;   // see RQ5
                    vipc_pkg::VK_SOFT: begin
                        // any number, enable flag ignored; wraps within 20 bits
                        vaddr_q <= 20'(vbase_q + {12'h0, VREQ.num, 2'b00}); // see RQ7, RQ8
                    end
                    default: begin
                        vaddr_q <= 20'h00000;
                        vref_q  <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign RDATA       = rdata_q;
    assign IRQ_PEND    = pend_q;
    assign IRQ_NUM     = {1'b0, pend_num_q};
    assign IRQ_LEVEL   = pend_lvl_q;
    assign VEC_VALID   = vvalid_q;
    assign VEC_ADDR    = vaddr_q;
    assign VEC_REFUSED = vref_q;

    // ==================================================================
    // checks
    // ==================================================================
    a_ien_after_reset: assert property (@(posedge SYS_CLK) SYS_RST |=> !ien_q) // see RQ16
        else $error("global enable not cleared by reset");

    // the winner index must be the one of the previous cycle, not the registered one now
    a_pend_three_cond: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ20
        pend_q |-> $past(ien_q && req_q[res_num] && (lvl_q[res_num] > ipl_q)))
        else $error("pending without all three conditions");

    a_level_zero_off: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ19
        pend_q |-> (pend_lvl_q != 3'h0))
        else $error("level zero reported as pending");

    a_nonmask_ungated: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ14
        (VREQ.req && !ien_q) |=> VEC_VALID)
        else $error("vector lookup gated by the enable flag");

    a_full_thresh_blocks: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ23
        (ipl_q == 3'h7) |=> !pend_q)
        else $error("threshold seven did not block");

    a_enable_blocks: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ16
        !ien_q |=> !pend_q)
        else $error("pending with enable cleared");

    a_event_sets_req: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ17
        (evt_vec[9] && ACK && ACK_NUM == 5'd9) |=> req_q[9])
        else $error("event lost against acceptance clear");

    a_one_write_ignored: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ18
        (WR && ADDR == 12'h054 && WDATA[3] && !req_q[21] && !evt_vec[21]) |=> !req_q[21])
        else $error("written one set a request bit");

    a_soft_vec_addr: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ7
        (VREQ.req && VREQ.kind == vipc_pkg::VK_SOFT) |=>
        VEC_VALID && VEC_ADDR == 20'($past(vbase_q) + {12'h0, $past(VREQ.num), 2'b00}))
        else $error("software vector address wrong");

    a_brk_redirect: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ3
        (VREQ.req && VREQ.kind == vipc_pkg::VK_BRK && VREQ.brk_byte == 8'hff) |=>
        VEC_ADDR == $past(vbase_q))
        else $error("break redirect missed");

    a_amatch_gate: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ4
        (VREQ.req && VREQ.kind == vipc_pkg::VK_AMATCH) |=> (VEC_REFUSED == !$past(amatch_en_q)))
        else $error("address match gate wrong");

    a_flag_readback: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see RQ21
        (RD && ADDR == vipc_pkg::FLAG_ADDR) |=>
        RDATA[6] == $past(ien_q) && RDATA[14:12] == $past(ipl_q))
        else $error("flag word readback wrong");

    c_pend_seen:    cover property (@(posedge SYS_CLK) disable iff (SYS_RST) !pend_q ##1 pend_q);
    c_brk_redirect: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        VREQ.req && VREQ.kind == vipc_pkg::VK_BRK && VREQ.brk_byte == 8'hff);
    c_set_clear:    cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        WR && ctrl_hit && !WDATA[3] && evt_vec[ctrl_idx]);
    c_ack_clear:    cover property (@(posedge SYS_CLK) disable iff (SYS_RST) ACK ##1 !pend_q);

endmodule // vipc_top

/* File: vipc_core_model.sv */
// cpu core model: acknowledges the winner that the block presents
`timescale 1ns/10ps
module vipc_core_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       en,
    input  wire logic       slow,
    input  wire logic       pend,
    input  wire logic [5:0] num,
    output logic            ack,
    output logic [4:0]      ack_num
);
    // ==========
    // acknowledge pacing
    // ==========
    int gap_q;
    // gap lets the pending flag fall before the next ack
    always_ff @(posedge clk) begin
        ack <= 1'b0;
        if (rst) begin
            gap_q   <= 0;
            ack_num <= 5'h00;
        end else if (gap_q > 0) gap_q <= gap_q - 1;
        else if (en && pend) begin
            ack     <= 1'b1;
            ack_num <= num[4:0];
            gap_q   <= slow ? 7 : 3;
        end
    end
endmodule // vipc_core_model

/* File: vipc_top_tb.sv */
// self-checking bench for the vectored interrupt priority control
`timescale 1ns/10ps
module vipc_top_tb;
    // ==========
    // stimulus and model state
    // ==========
    logic        SYS_CLK = 1'b0, SYS_RST = 1'b1, WR = 1'b0, RD = 1'b0, core_en = 1'b0, slow = 1'b0;
    logic        ACK, IRQ_PEND, VEC_VALID, VEC_REFUSED;
    logic [11:0] ADDR = 12'h000;
    logic [31:0] WDATA = 32'h0, RDATA, lf = 32'hf6b9;
    logic [4:0]  ACK_NUM;
    logic [5:0]  IRQ_NUM;
    logic [2:0]  IRQ_LEVEL;
    logic [19:0] VEC_ADDR;
    vipc_pkg::vipc_evt_s  EVT = '0;
    vipc_pkg::vipc_vreq_s VREQ = '0;
    int num_errors = 0, checks_done = 0, pn = 0, ien, cpu_priority_threshold, e_pend, e_num, e_lvl, m_req[32], m_lvl[32];
    int pos[4:31] = '{29,20,19,18,13,14,12,11,10,9,8,7,6,3,2,1,0,21,22,23,24,25,15,16,17,26,27,28};
    int alt[5] = '{31, 30, 5, 4, 13}, altn[5] = '{8, 9, 15, 16, 0};
    always #12.5 SYS_CLK = ~SYS_CLK;
    vipc_top vipc_top_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .EVT(EVT), .ACK(ACK), .ACK_NUM(ACK_NUM), .IRQ_PEND(IRQ_PEND),
        .IRQ_NUM(IRQ_NUM), .IRQ_LEVEL(IRQ_LEVEL), .VREQ(VREQ), .VEC_VALID(VEC_VALID),
        .VEC_ADDR(VEC_ADDR), .VEC_REFUSED(VEC_REFUSED));
    vipc_core_model vipc_core_model_i (.clk(SYS_CLK), .rst(SYS_RST), .en(core_en), .slow(slow),
        .pend(IRQ_PEND), .num(IRQ_NUM), .ack(ACK), .ack_num(ACK_NUM));
    // ==========
    // helpers
    // ==========
    function automatic logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge SYS_CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
        @(posedge SYS_CLK) WR <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] exp);
        @(posedge SYS_CLK) {ADDR, RD} <= {a, 1'b1};
        @(posedge SYS_CLK) RD <= 1'b0;
        #1 chk(RDATA, exp);
    endtask
    task automatic pulse(int b, int n);
        @(posedge SYS_CLK) {EVT, pn} <= {32'h1 << b, n};
        @(posedge SYS_CLK) {EVT, pn} <= 64'h0;
    endtask
    task automatic vq(int k, int n, logic [7:0] bb, logic [19:0] ea, logic er);
        @(posedge SYS_CLK) VREQ <= '{1'b1, vipc_pkg::vipc_vkind_e'(k), 6'(n), bb};
        @(posedge SYS_CLK) VREQ.req <= 1'b0;
        #1 chk({VEC_VALID, VEC_REFUSED, er ? 20'h0 : VEC_ADDR}, {1'b1, er, ea});
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // reference model: winner from state before this edge, then updates
    always @(posedge SYS_CLK) begin : model
        int bl, bn;
        bl = 0;
        bn = 0;
        if (SYS_RST) begin
            {ien, cpu_priority_threshold, e_pend} = 96'h0;
            m_req = '{default: 0};
            m_lvl = '{default: 0};
        end else begin
            for (int n = 31; n >= 4; n--) // descending, so a tie keeps the lowest number
                if (ien && m_req[n] && m_lvl[n] > cpu_priority_threshold && m_lvl[n] >= bl) {bl, bn} = {m_lvl[n], n};
            {e_pend, e_num, e_lvl} = {int'(bl > 0), bn, bl};
            if (ACK) m_req[ACK_NUM] = 0;
            if (WR && ADDR >= 12'h010 && ADDR < 12'h080) begin
                m_lvl[ADDR[6:2]] = WDATA[2:0];
                if (!WDATA[3]) m_req[ADDR[6:2]] = 0;
            end
            if (WR && ADDR == 12'h100) {ien, cpu_priority_threshold} = {31'h0, WDATA[6], 29'h0, WDATA[14:12]};
            if (pn >= 4) m_req[pn] = 1; // set wins over any clear
        end
    end
    // compare outputs mid-cycle, when settled
    always @(negedge SYS_CLK) if (!SYS_RST) begin
        chk(IRQ_PEND, e_pend);
        if (e_pend) chk({IRQ_NUM, IRQ_LEVEL}, {e_num[5:0], e_lvl[2:0]});
    end
    initial begin
        #(25 * 30000);
        num_errors++;
        tally_and_finish;
    end
    // ==========
    // main sequence
    // ==========
    initial begin
        int n;
        repeat (6) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        rd(12'h100, 32'h0);
        rd(12'h200, 32'h0);
        core_en <= 1'b1;
        for (int i = 0; i < 600; i++) begin
            lf = nx(lf);
            n = 4 + lf[15:11] % 28;
            slow <= lf[8];
            case (lf[1:0])
                2'd0: wr(12'h100, (lf & 32'h7000) | {lf[9] | lf[10], 6'h0});
                2'd1: wr({lf[8:4], 2'b00}, lf & 32'hf);
                default: pulse(pos[n], n);
            endcase
        end
        core_en <= 1'b0;
        wr(12'h35f, 32'hc0);
        wr(12'h108, 32'h3);
        foreach (alt[i]) pulse(alt[i], altn[i]);
        for (int k = 0; k < 32; k++) rd(12'(4 * k), k < 4 ? 0 : m_req[k] * 8 + m_lvl[k]);
        rd(12'h100, ien * 64 + cpu_priority_threshold * 4096);
        rd(12'h10c, e_lvl * 512 + e_pend * 256 + e_num);
        rd(12'h35f, 32'hc0);
        wr(12'h104, lf & 32'hfffff);
        for (int k = 0; k < 9; k++) vq(k, 0, 8'h00, 20'hfffdc + 20'(4 * k), 1'b0);
        vq(2, 0, 8'hff, lf[19:0], 1'b0);
        vq(9, 63, 8'h00, lf[19:0] + 20'd252, 1'b0);
        wr(12'h108, 32'h0);
        vq(3, 0, 8'h00, 20'h0, 1'b1);
        tally_and_finish;
    end
endmodule // vipc_top_tb
